// >>> hw/balu_pkg.sv
package balu_pkg;
   // operation codes presented by the decode stage
   typedef enum logic [4:0] {
      BALU_OP_NONE = 5'h00,
      BALU_OP_ADD = 5'h01,
      BALU_OP_ADD_CARRY = 5'h02,
      BALU_OP_SUB_BORROW = 5'h03,
      BALU_OP_INC = 5'h04,
      BALU_OP_DECREMENT = 5'h05,
      BALU_OP_INC_POINTER = 5'h06,
      BALU_OP_MULTIPLY = 5'h07,
      BALU_OP_DIV = 5'h08,
      BALU_OP_DA = 5'h09,
      BALU_OP_AND = 5'h0a,
      BALU_OP_OR = 5'h0b,
      BALU_OP_XOR = 5'h0c,
      BALU_OP_CLEAR = 5'h0d,
      BALU_OP_COMPLEMENT = 5'h0e,
      BALU_OP_ROT_LEFT = 5'h0f,
      BALU_OP_ROT_LEFT_CARRY = 5'h10,
      BALU_OP_ROT_RIGHT = 5'h11,
      BALU_OP_ROT_RIGHT_CARRY = 5'h12,
      BALU_OP_SWAP = 5'h13
   } balu_op_e;
   // operand source / destination forms
   typedef enum logic [2:0] {
      BALU_SRC_ACC = 3'h0,
      BALU_SRC_REG = 3'h1,
      BALU_SRC_DIR = 3'h2,
      BALU_SRC_IND = 3'h3,
      BALU_SRC_IMM = 3'h4
   } balu_src_e;
   typedef enum logic [1:0] {
      BALU_ST_IDLE = 2'b00,
      BALU_ST_BUSY = 2'b01,
      BALU_ST_DONE = 2'b11
   } balu_state_e;
   localparam logic [1:0] BALU_LEN_1 = 2'h1;
   localparam logic [1:0] BALU_LEN_2 = 2'h2;
   localparam logic [1:0] BALU_LEN_3 = 2'h3;
   localparam logic [2:0] BALU_CYC_1 = 3'h1;
   localparam logic [2:0] BALU_CYC_2 = 3'h2;
   localparam logic [2:0] BALU_CYC_3 = 3'h3;
   localparam logic [2:0] BALU_CYC_6 = 3'h6;
   localparam logic [7:0] BALU_ACC_RST = 8'h00;
   localparam logic [7:0] BALU_B_RST = 8'h00;
   localparam logic [15:0] BALU_PTR16_RST = 16'h0000;
   localparam int BALU_NIB = 4;
   localparam logic [3:0] BALU_BCD_NINE = 4'h9;
   localparam logic [7:0] BALU_ADJ_LO = 8'h06;
   localparam logic [7:0] BALU_ADJ_HI = 8'h60;
endpackage

// >>> hw/balu_unit.sv
`timescale 1ns/1ps
module balu_unit
   import balu_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire balu_op_e op,
   input wire balu_src_e src,
   input wire logic dst_direct,
   input wire logic [7:0] reg_data,
   input wire logic [7:0] dir_addr,
   input wire logic [7:0] ptr_data,
   input wire logic [7:0] imm_data,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic done,
   output logic [1:0] instr_len,
   output logic [7:0] mem_addr,
   output logic mem_indirect,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic reg_we,
   output logic [7:0] reg_wdata,
   output logic [7:0] acc,
   output logic [7:0] b_reg,
   output logic [15:0] data_ptr,
   output logic cy,
   output logic ac,
   output logic ov
);
   balu_state_e state_q, state_d;
   logic [2:0] cnt_q;
   logic [2:0] cyc_need;
   logic [1:0] len_need;
   logic [7:0] acc_q, b_q, opnd, res;
   logic [15:0] data_ptr_q;
   logic [7:0] mem_addr_q;
   logic ind_q;
   logic cy_q, ac_q, ov_q;
   logic res_cy, res_ac, res_ov;
   logic [7:0] mem_wdata_q, reg_wdata_q;
   logic mem_we_q, reg_we_q, done_q;
   logic [1:0] len_q;
   balu_op_e op_q;
   balu_src_e src_q;
   logic dst_q;
   logic [7:0] imm_q, reg_q;

   function automatic logic [2:0] cyc_of(balu_op_e o, balu_src_e s, logic d);
      logic [2:0] c;
      c = BALU_CYC_1;
      case (o)
         BALU_OP_ADD, BALU_OP_ADD_CARRY, BALU_OP_SUB_BORROW, BALU_OP_AND, BALU_OP_OR,
         BALU_OP_XOR: begin
            if (d) begin
               c = BALU_CYC_3;
            end else if (s == BALU_SRC_REG) begin
               c = BALU_CYC_1;
            end else begin
               c = BALU_CYC_2;
            end
         end
         BALU_OP_INC, BALU_OP_DECREMENT: begin
            case (s)
               BALU_SRC_ACC: c = BALU_CYC_1;
               BALU_SRC_REG: c = BALU_CYC_2;
               default: c = BALU_CYC_3;
            endcase
         end
         BALU_OP_MULTIPLY: c = BALU_CYC_2;
         BALU_OP_DA: c = BALU_CYC_3;
         BALU_OP_DIV: c = BALU_CYC_6;
         default: c = BALU_CYC_1;
      endcase
      return c;
   endfunction

   function automatic logic [1:0] len_of(balu_op_e o, balu_src_e s, logic d);
      logic [1:0] l;
      l = BALU_LEN_1;
      if (d) begin
         l = (s == BALU_SRC_IMM) ? BALU_LEN_3 : BALU_LEN_2;
      end else if (o inside {BALU_OP_ADD, BALU_OP_ADD_CARRY, BALU_OP_SUB_BORROW, BALU_OP_AND,
                             BALU_OP_OR, BALU_OP_XOR, BALU_OP_INC, BALU_OP_DECREMENT}) begin
         l = (s == BALU_SRC_DIR || s == BALU_SRC_IMM) ? BALU_LEN_2 : BALU_LEN_1;
      end
      return l;
   endfunction

   assign cyc_need = cyc_of(op, src, dst_direct);
   assign len_need = len_of(op, src, dst_direct);
   wire last_cyc = (cnt_q == BALU_CYC_1);
   wire fire_one = start && (state_q == BALU_ST_IDLE) && (cyc_need == BALU_CYC_1);
   wire take = start && (state_q == BALU_ST_IDLE);
   wire finish = fire_one || (state_q == BALU_ST_BUSY && last_cyc);
   wire balu_op_e eop = (state_q == BALU_ST_IDLE) ? op : op_q;
   wire balu_src_e esrc = (state_q == BALU_ST_IDLE) ? src : src_q;
   wire edst = (state_q == BALU_ST_IDLE) ? dst_direct : dst_q;
   wire [7:0] eimm = (state_q == BALU_ST_IDLE) ? imm_data : imm_q;
   wire [7:0] ereg = (state_q == BALU_ST_IDLE) ? reg_data : reg_q;

   // operand select across addressing forms
   always_comb begin
      case (esrc)
         BALU_SRC_REG: opnd = ereg;
         BALU_SRC_IMM: opnd = eimm;
         BALU_SRC_ACC: opnd = acc_q;
         default: opnd = mem_rdata;
      endcase
   end

   // arithmetic and logic results
   wire [7:0] lhs = edst ? mem_rdata : acc_q;
   wire [7:0] rhs = edst ? ((esrc == BALU_SRC_IMM) ? eimm : acc_q) : opnd;
   wire cin = (eop == BALU_OP_ADD) ? 1'b0 : cy_q;
   wire [8:0] add_s = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
   wire [4:0] add_n = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
   wire [8:0] sub_s = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, cy_q};
   wire [4:0] sub_n = {1'b0, acc_q[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy_q};
   wire [7:0] incdec_src = (esrc == BALU_SRC_ACC) ? acc_q : opnd;
   wire [15:0] prod = acc_q * b_q;
   wire div_zero = (b_q == 8'h00);
   wire [7:0] quot = div_zero ? 8'hff : acc_q / b_q;
   wire [7:0] remd = div_zero ? acc_q : acc_q % b_q;
   wire lo_fix = (acc_q[3:0] > BALU_BCD_NINE) || ac_q;
   wire [8:0] da1 = {1'b0, acc_q} + (lo_fix ? {1'b0, BALU_ADJ_LO} : 9'h000);
   wire hi_fix = (da1[7:BALU_NIB] > BALU_BCD_NINE) || cy_q || da1[8];
   wire [8:0] da2 = da1 + (hi_fix ? {1'b0, BALU_ADJ_HI} : 9'h000);
   wire [7:0] and_v, or_v, xor_v;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bit
         assign and_v[gi] = lhs[gi] & rhs[gi];
         assign or_v[gi] = lhs[gi] | rhs[gi];
         assign xor_v[gi] = lhs[gi] ^ rhs[gi];
      end
   endgenerate

   always_comb begin
      res = acc_q;
      res_cy = cy_q;
      res_ac = ac_q;
      res_ov = ov_q;
      case (eop)
         BALU_OP_ADD, BALU_OP_ADD_CARRY: begin
            res = add_s[7:0];
            res_cy = add_s[8];
            res_ac = add_n[4];
            res_ov = (acc_q[7] == opnd[7]) && (add_s[7] != acc_q[7]);
         end
         BALU_OP_SUB_BORROW: begin
            res = sub_s[7:0];
            res_cy = sub_s[8];
            res_ac = sub_n[4];
            res_ov = (acc_q[7] != opnd[7]) && (sub_s[7] != acc_q[7]);
         end
         BALU_OP_INC: res = incdec_src + 8'h01;
         BALU_OP_DECREMENT: res = incdec_src - 8'h01;
         BALU_OP_MULTIPLY: begin
            res = prod[7:0];
            res_cy = 1'b0;
            res_ov = (prod[15:8] != 8'h00);
         end
         BALU_OP_DIV: begin
            res = quot;
            res_cy = 1'b0;
            res_ov = div_zero;
         end
         BALU_OP_DA: begin
            res = da2[7:0];
            res_cy = hi_fix;
         end
         BALU_OP_AND: res = and_v;
         BALU_OP_OR: res = or_v;
         BALU_OP_XOR: res = xor_v;
         BALU_OP_CLEAR: res = 8'h00;
         BALU_OP_COMPLEMENT: res = ~acc_q;
         BALU_OP_ROT_LEFT: res = {acc_q[6:0], acc_q[7]};
         BALU_OP_ROT_RIGHT: res = {acc_q[0], acc_q[7:1]};
         BALU_OP_ROT_LEFT_CARRY: begin
            res = {acc_q[6:0], cy_q};
            res_cy = acc_q[7];
         end
         BALU_OP_ROT_RIGHT_CARRY: begin
            res = {cy_q, acc_q[7:1]};
            res_cy = acc_q[0];
         end
         BALU_OP_SWAP: res = {acc_q[3:0], acc_q[7:4]};
         default: res = acc_q;
      endcase
   end

   wire to_mem = edst || ((eop == BALU_OP_INC || eop == BALU_OP_DECREMENT) &&
                 (esrc == BALU_SRC_DIR || esrc == BALU_SRC_IND));
   wire to_reg = (eop == BALU_OP_INC || eop == BALU_OP_DECREMENT) && (esrc == BALU_SRC_REG);
   wire to_acc = !to_mem && !to_reg && (eop != BALU_OP_INC_POINTER) &&
                 (eop != BALU_OP_NONE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         BALU_ST_IDLE: if (take && !fire_one) state_d = BALU_ST_BUSY;
         BALU_ST_BUSY: if (last_cyc) state_d = BALU_ST_DONE;
         BALU_ST_DONE: state_d = BALU_ST_IDLE;
         default: state_d = BALU_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= BALU_ST_IDLE;
         cnt_q <= 3'h0;
      end else begin
         state_q <= (state_d == BALU_ST_DONE) ? BALU_ST_IDLE : state_d;
         if (take) cnt_q <= cyc_need - BALU_CYC_1;
         else if (state_q == BALU_ST_BUSY) cnt_q <= cnt_q - 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (take) begin
         op_q <= op;
         src_q <= src;
         dst_q <= dst_direct;
         imm_q <= imm_data;
         reg_q <= reg_data;
         mem_addr_q <= (src == BALU_SRC_IND) ? ptr_data : dir_addr;
         ind_q <= (src == BALU_SRC_IND) && !dst_direct;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         acc_q <= BALU_ACC_RST;
         b_q <= BALU_B_RST;
         data_ptr_q <= BALU_PTR16_RST;
         {cy_q, ac_q, ov_q} <= 3'b000;
         {done_q, mem_we_q, reg_we_q} <= 3'b000;
         mem_wdata_q <= 8'h00;
         reg_wdata_q <= 8'h00;
         len_q <= 2'h0;
      end else begin
         done_q <= finish;
         mem_we_q <= finish && to_mem;
         reg_we_q <= finish && to_reg;
         if (take) len_q <= len_need;
         if (finish) begin
            if (to_acc) acc_q <= res;
            if (to_mem) mem_wdata_q <= res;
            if (to_reg) reg_wdata_q <= res;
            if (eop == BALU_OP_MULTIPLY) b_q <= prod[15:8];
            if (eop == BALU_OP_DIV) b_q <= remd;
            if (eop == BALU_OP_INC_POINTER) data_ptr_q <= data_ptr_q + 16'h0001;
            {cy_q, ac_q, ov_q} <= {res_cy, res_ac, res_ov};
         end
      end
   end

   assign busy = (state_q != BALU_ST_IDLE);
   assign done = done_q;
   assign instr_len = len_q;
   // latched address holds through the write-back cycle unless a new request is taken in that cycle
   assign mem_addr = take ? ((src == BALU_SRC_IND) ? ptr_data : dir_addr) : mem_addr_q;
   assign mem_indirect = take ? (src == BALU_SRC_IND) : ind_q;
   assign mem_we = mem_we_q;
   assign mem_wdata = mem_wdata_q;
   assign reg_we = reg_we_q;
   assign reg_wdata = reg_wdata_q;
   assign acc = acc_q;
   assign b_reg = b_q;
   assign data_ptr = data_ptr_q;
   assign {cy, ac, ov} = {cy_q, ac_q, ov_q};

   logic [2:0] mon_q;
   always_ff @(posedge clock) begin
      if (rst) mon_q <= 3'h0;
      else if (take) mon_q <= 3'h1;
      else if (done_q) mon_q <= 3'h0;
      else if (mon_q != 3'h0) mon_q <= mon_q + 3'h1;
   end

   AST_DIV_SIX: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_DIV) |=> !done [*5] ##1 done)
      else $error("divide did not finish in six cycles");
   AST_MULTIPLY_TWO: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_MULTIPLY) |=> !done ##1 done)
      else $error("multiply did not finish in two cycles");
   AST_DA_THREE: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_DA) |=> !done [*2] ##1 done)
      else $error("decimal adjust did not take three cycles");
   AST_REG_ADD_ONE: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_ADD && src == BALU_SRC_REG && !dst_direct) |=> done)
      else $error("register add not one cycle");
   AST_INC_MEM_THREE: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_INC && src == BALU_SRC_DIR) |-> ##3 (done && mem_we))
      else $error("direct increment write not after three cycles");
   AST_LOGIC_DIR: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_XOR && dst_direct && src == BALU_SRC_IMM)
      |-> ##1 (instr_len == BALU_LEN_3) ##2 mem_we)
      else $error("xor into direct byte has wrong length or timing");
   AST_COMPLEMENT: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_COMPLEMENT) |=> (acc == ~$past(acc)))
      else $error("complement result wrong");
   AST_ROT_CARRY: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_ROT_LEFT_CARRY) |=> (cy == $past(acc[7]) && acc[0] == $past(cy)))
      else $error("rotate through carry wrong");
   AST_AND_IMM: assert property (@(posedge clock) disable iff (rst)
      (take && op == BALU_OP_AND && src == BALU_SRC_IMM && !dst_direct)
      |-> ##2 (done && acc == ($past(acc, 2) & $past(imm_data, 2))))
      else $error("immediate and not done in two cycles");
   AST_NO_HANG: assert property (@(posedge clock) disable iff (rst)
      mon_q != 3'h7)
      else $error("operation exceeded six cycles");
endmodule

// >>> verification/balu_ram_model.sv
`timescale 1ns/1ps
// 256-byte internal ram seen by the datapath
module balu_ram_model (
   input wire logic clock,
   input wire logic [7:0] mem_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [256];
   // every byte starts out holding its own address
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i);
      end
   end
   // read answers at once, write lands at the edge
   assign mem_rdata = mem[mem_addr];
   always @(posedge clock) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import balu_pkg::*;
   typedef struct packed {
      balu_op_e op; balu_src_e src; logic [7:0] d; logic [7:0] a;
      logic [7:0] acc; logic cy; logic [2:0] cyc; logic [1:0] len;
   } balu_row_s;
   logic clock, rst, start, dst_direct, busy, done, mem_indirect, mem_we, reg_we, cy, ac, ov;
   balu_op_e op;
   balu_src_e src;
   logic [7:0] reg_data, dir_addr, ptr_data, imm_data, mem_rdata, mem_addr, mem_wdata;
   logic [7:0] reg_wdata, acc, b_reg;
   logic [1:0] instr_len;
   logic [15:0] data_ptr;
   int fail_count, check_count, n;
   balu_row_s rows [31] = '{
      '{BALU_OP_ADD, BALU_SRC_IMM, 8'h3c, 8'h00, 8'h3c, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_ADD, BALU_SRC_REG, 8'hd0, 8'h00, 8'h0c, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_ADD_CARRY, BALU_SRC_DIR, 8'h00, 8'h20, 8'h2d, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_ADD_CARRY, BALU_SRC_IND, 8'h00, 8'hf0, 8'h1d, 1'b1, 3'h2, 2'h1},
      '{BALU_OP_SUB_BORROW, BALU_SRC_IMM, 8'h1d, 8'h00, 8'hff, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_SUB_BORROW, BALU_SRC_REG, 8'h0f, 8'h00, 8'hef, 1'b0, 3'h1, 2'h1},
      '{BALU_OP_SUB_BORROW, BALU_SRC_DIR, 8'h00, 8'h0e, 8'he1, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_SUB_BORROW, BALU_SRC_IND, 8'h00, 8'he2, 8'hff, 1'b1, 3'h2, 2'h1},
      '{BALU_OP_INC, BALU_SRC_ACC, 8'h00, 8'h00, 8'h00, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_DECREMENT, BALU_SRC_ACC, 8'h00, 8'h00, 8'hff, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_COMPLEMENT, BALU_SRC_ACC, 8'h00, 8'h00, 8'h00, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_OR, BALU_SRC_IMM, 8'ha5, 8'h00, 8'ha5, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_AND, BALU_SRC_REG, 8'h3c, 8'h00, 8'h24, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_AND, BALU_SRC_IMM, 8'hf0, 8'h00, 8'h20, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_XOR, BALU_SRC_DIR, 8'h00, 8'h35, 8'h15, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_XOR, BALU_SRC_IND, 8'h00, 8'h0f, 8'h1a, 1'b1, 3'h2, 2'h1},
      '{BALU_OP_XOR, BALU_SRC_IMM, 8'h3c, 8'h00, 8'h26, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_ROT_LEFT, BALU_SRC_ACC, 8'h00, 8'h00, 8'h4c, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_ROT_LEFT_CARRY, BALU_SRC_ACC, 8'h00, 8'h00, 8'h99, 1'b0, 3'h1, 2'h1},
      '{BALU_OP_ROT_RIGHT, BALU_SRC_ACC, 8'h00, 8'h00, 8'hcc, 1'b0, 3'h1, 2'h1},
      '{BALU_OP_ROT_RIGHT_CARRY, BALU_SRC_ACC, 8'h00, 8'h00, 8'h66, 1'b0, 3'h1, 2'h1},
      '{BALU_OP_SWAP, BALU_SRC_ACC, 8'h00, 8'h00, 8'h66, 1'b0, 3'h1, 2'h1},
      '{BALU_OP_ADD, BALU_SRC_IMM, 8'h35, 8'h00, 8'h9b, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_DA, BALU_SRC_ACC, 8'h00, 8'h00, 8'h01, 1'b1, 3'h3, 2'h1},
      '{BALU_OP_CLEAR, BALU_SRC_ACC, 8'h00, 8'h00, 8'h00, 1'b1, 3'h1, 2'h1},
      '{BALU_OP_OR, BALU_SRC_DIR, 8'h00, 8'h40, 8'h40, 1'b1, 3'h2, 2'h2},
      '{BALU_OP_AND, BALU_SRC_IND, 8'h00, 8'hc3, 8'h40, 1'b1, 3'h2, 2'h1},
      '{BALU_OP_ADD, BALU_SRC_DIR, 8'h00, 8'h10, 8'h50, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_ADD, BALU_SRC_IND, 8'h00, 8'hb0, 8'h00, 1'b1, 3'h2, 2'h1},
      '{BALU_OP_ADD_CARRY, BALU_SRC_IMM, 8'h01, 8'h00, 8'h02, 1'b0, 3'h2, 2'h2},
      '{BALU_OP_ADD_CARRY, BALU_SRC_REG, 8'hfe, 8'h00, 8'h00, 1'b1, 3'h1, 2'h1}
   };

   balu_unit DUT (.clock(clock), .rst(rst), .start(start), .op(op), .src(src),
      .dst_direct(dst_direct), .reg_data(reg_data), .dir_addr(dir_addr), .ptr_data(ptr_data),
      .imm_data(imm_data), .mem_rdata(mem_rdata), .busy(busy), .done(done),
      .instr_len(instr_len), .mem_addr(mem_addr), .mem_indirect(mem_indirect), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .reg_we(reg_we), .reg_wdata(reg_wdata), .acc(acc), .b_reg(b_reg),
      .data_ptr(data_ptr), .cy(cy), .ac(ac), .ov(ov));
   balu_ram_model ram (.clock(clock), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one request; hold keeps start up with another op while busy
   task automatic go(input balu_op_e o, input balu_src_e s, input logic dd,
         input logic [7:0] d, input logic [7:0] a, input int hold, output int cnt);
      @(posedge clock);
      start <= 1'b1;
      op <= o;
      src <= s;
      dst_direct <= dd;
      reg_data <= d;
      imm_data <= d;
      dir_addr <= a;
      ptr_data <= a;
      @(posedge clock);
      cnt = 1;
      if (hold == 0) start <= 1'b0;
      else op <= BALU_OP_CLEAR;
      #1;
      while (done !== 1'b1 && cnt < 10) begin
         @(posedge clock);
         cnt++;
         if (cnt == hold) start <= 1'b0;
         #1;
      end
   endtask

   // memory write-back forms
   task automatic wr(input balu_op_e o, input balu_src_e s, input logic dd,
         input logic [7:0] d, input logic [7:0] a, input logic [7:0] w, input int c,
         input logic [1:0] l);
      int k;
      go(o, s, dd, d, a, 0, k);
      chk(16'(k), 16'(c));
      chk(16'(instr_len), 16'(l));
      chk({mem_we, mem_wdata}, {8'h01, w});
      chk(16'(mem_addr), 16'(a));
   endtask

   initial begin
      #200_000;
      fail_count++;
      conclude();
   end

   initial begin
      fail_count = 0;
      check_count = 0;
      rst = 1'b1;
      start = 1'b0;
      op = BALU_OP_NONE;
      src = BALU_SRC_ACC;
      {dst_direct, reg_data, dir_addr, ptr_data, imm_data} = '0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk({acc, b_reg}, 16'h0000);
      chk(data_ptr, 16'h0000);
      chk({11'h000, cy, ac, ov, busy, done}, 16'h0000);
      foreach (rows[i]) begin
         go(rows[i].op, rows[i].src, 1'b0, rows[i].d, rows[i].a, 0, n);
         chk({acc, 7'h00, cy}, {rows[i].acc, 7'h00, rows[i].cy});
         chk(16'(n), 16'(rows[i].cyc));
         chk(16'(instr_len), 16'(rows[i].len));
      end
      go(BALU_OP_ADD, BALU_SRC_IMM, 1'b0, 8'h0c, 8'h00, 0, n);
      go(BALU_OP_DIV, BALU_SRC_ACC, 1'b0, 8'h00, 8'h00, 0, n);
      chk(16'(n), 16'h0006);
      chk({acc, b_reg}, 16'hff0c);
      chk(16'(ov), 16'h0001);
      go(BALU_OP_MULTIPLY, BALU_SRC_ACC, 1'b0, 8'h00, 8'h00, 0, n);
      chk(16'(n), 16'h0002);
      chk({acc, b_reg}, 16'hf40b);
      chk({14'h0000, cy, ov}, 16'h0001);
      go(BALU_OP_DIV, BALU_SRC_ACC, 1'b0, 8'h00, 8'h00, 5, n);
      chk(16'(n), 16'h0006);
      chk({acc, b_reg}, 16'h1602);
      @(posedge clock);
      #1;
      chk({7'h00, busy, acc}, 16'h0016);
      go(BALU_OP_INC_POINTER, BALU_SRC_ACC, 1'b0, 8'h00, 8'h00, 0, n);
      chk({data_ptr[7:0], 6'h00, instr_len}, 16'h0101);
      chk(16'(n), 16'h0001);
      go(BALU_OP_INC, BALU_SRC_REG, 1'b0, 8'hff, 8'h00, 0, n);
      chk({7'h00, reg_we, reg_wdata}, 16'h0100);
      chk(16'(n), 16'h0002);
      wr(BALU_OP_DECREMENT, BALU_SRC_IND, 1'b0, 8'h00, 8'h80, 8'h7f, 3, 2'h1);
      chk(16'(mem_indirect), 16'h0001);
      wr(BALU_OP_INC, BALU_SRC_DIR, 1'b0, 8'h00, 8'h90, 8'h91, 3, 2'h2);
      chk(16'(mem_indirect), 16'h0000);
      wr(BALU_OP_AND, BALU_SRC_ACC, 1'b1, 8'h00, 8'hf3, 8'h12, 3, 2'h2);
      wr(BALU_OP_OR, BALU_SRC_IMM, 1'b1, 8'h0f, 8'hc0, 8'hcf, 3, 2'h3);
      wr(BALU_OP_XOR, BALU_SRC_IMM, 1'b1, 8'hff, 8'h55, 8'haa, 3, 2'h3);
      wr(BALU_OP_XOR, BALU_SRC_ACC, 1'b1, 8'h00, 8'ha1, 8'hb7, 3, 2'h2);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      #1;
      chk({acc, b_reg}, 16'h0000);
      chk(data_ptr, 16'h0000);
      conclude();
   end
endmodule
